// File: ppb_regs.svh
// timing counts, frame layout and fixed patterns of the burst transceiver
`ifndef PPB_REGS_SVH
`define PPB_REGS_SVH
// ----------------------------------------
// clock and rates
// ----------------------------------------
`define PPB_CLK_HZ    200000000
`define PPB_CLK_NS    5
`define PPB_BIT_HZ    384000
`define PPB_DCL_HZ    1536000
`define PPB_GUARD_NS  5200
`define PPB_WAKE_US   500
`define PPB_FRM_SLOTS 192
// ----------------------------------------
// frame layout
// ----------------------------------------
`define PPB_FRM_BITS  38
`define PPB_M_IDX     37
`define PPB_SCR_LIM   5'h1f
// ----------------------------------------
// fixed info patterns, first bit in msb
// ----------------------------------------
`define PPB_WAKE_PAT  38'h0444557c00
`define PPB_WAKE_LEN  6'h24
`define PPB_SYNC_PAT  38'h04444aaafc
`define PPB_SYNC_LEN  6'h25
`define PPB_T1_PAT    38'h2000000000
`define PPB_T1_LEN    6'h09
`endif

// File: ppb_pkg.sv
// types shared by the burst transceiver
package ppb_pkg;
   // upstream info selection
   typedef enum logic [2:0] {
      INFO_SILENT = 3'h0,
      INFO_WAKE   = 3'h1,
      INFO_SYNC   = 3'h2,
      INFO_DATA   = 3'h3,
      SINGLE_PULSE_TEST     = 3'h4,
      CONTINUOUS_PULSE_TEST     = 3'h5
   } info_t;
   // transmit sequencer
   typedef enum logic [1:0] {
      TX_IDLE  = 2'h0,
      TX_GUARD = 2'h1,
      TX_SEND  = 2'h2
   } tx_state_t;
   // receive framer
   typedef enum logic [1:0] {
      RX_HUNT = 2'h0,
      RX_BITS = 2'h1,
      RX_TAIL = 2'h2
   } rx_state_t;
endpackage : ppb_pkg

// File: ping_pong_burst_transceiver.sv
// terminal-side burst framer, line coder, scrambler and highway clocks
`timescale 1ns/10ps
`include "ppb_regs.svh"

module ping_pong_burst_transceiver #(
   parameter int WAKE_CYC  = `PPB_WAKE_US * 1000 / `PPB_CLK_NS,
   parameter int LOCK_SLOT = 0
) (
   // clock and reset
   input  wire logic           clk_in,
   input  wire logic           rst_n_in,
   // mode controls
   input  wire ppb_pkg::info_t info_sel_in,
   input  wire logic           activated_in,
   input  wire logic           terminal_repeater_mode_in,
   input  wire logic           t_mapping_select_in,
   input  wire logic           bus_accessed_flag_in,
   // upstream user data
   input  wire logic [15:0]    tx_b1_in,
   input  wire logic [15:0]    tx_b2_in,
   input  wire logic [3:0]     tx_d_in,
   input  wire logic           tx_service_in,
   // line comparators and drivers
   input  wire logic           rx_pos_in,
   input  wire logic           rx_neg_in,
   output logic                line_pos_out,
   output logic                line_neg_out,
   // downstream user data
   output logic [15:0]         rx_b1_out,
   output logic [15:0]         rx_b2_out,
   output logic [3:0]          rx_d_out,
   output logic                rx_valid_out,
   output logic                rx_service_out,
   output logic                rx_stop_go_out,
   output logic                rx_avail_busy_out,
   output logic                rx_lead_cv_out,
   // highway clocks
   output logic                frame_sync_out,
   output logic                dcl_out,
   output logic                bit_clk_out
);
   // ----------------------------------------
   // derived counts
   // ----------------------------------------
   localparam int BIT_CYC   = `PPB_CLK_HZ / `PPB_BIT_HZ;
   localparam int GUARD_CYC = (`PPB_GUARD_NS + `PPB_CLK_NS - 1) / `PPB_CLK_NS;
   localparam int DCL_HALF  = `PPB_CLK_HZ / (2 * `PPB_DCL_HZ);

   // B-channel bit positions inside a frame
   function automatic logic b_pos(input logic [5:0] i);
      b_pos = (i >= 6'h01 && i <= 6'h10) || (i >= 6'h13 && i <= 6'h22);
   endfunction : b_pos

   // self-synchronising scrambler step, same formula both ways;
   // supervision looks at line history only so both ends agree
   function automatic logic [5:0] scr(input logic b, input logic [7:0] h,
                                      input logic [4:0] c);
      logic       p;
      logic       inv;
      logic [4:0] n;
      p   = (h[0] == h[7]);
      inv = p && (c == `PPB_SCR_LIM);
      n   = (p && !inv) ? c + 5'h01 : 5'h00;
      scr = {b ^ h[5] ^ h[6] ^ inv, n};
   endfunction : scr

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic [1:0] rst_q;  // release shift
   logic       rst_n;  // synchronised reset
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) rst_q <= 2'h0;
      else           rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   // ----------------------------------------
   // receive framer
   // ----------------------------------------
   ppb_pkg::rx_state_t rx_st_q, rx_st_d;
   logic [10:0] rx_ph_q, rx_ph_d;      // sample phase, internal 384 kHz
   logic [5:0]  rx_idx_q, rx_idx_d;    // bit index in frame
   logic [37:0] rx_w_q, rx_w_d;        // descrambled frame bits
   logic [7:0]  rx_h_q, rx_h_d;        // line history of B bits
   logic [4:0]  rx_c_q, rx_c_d;        // supervision count
   logic        rx_lp_q, rx_lp_d;      // polarity of last mark
   logic        rx_lh_q, rx_lh_d;      // a mark has been seen
   logic        rx_fcv_q, rx_fcv_d;    // violation on lead bit
   logic [1:0]  rx_sf_q, rx_sf_d;      // superframe position
   logic        m_tick_q, m_tick_d;    // M-bit sampled
   logic        cv_tick_q, cv_tick_d;  // violation sampled
   logic [15:0] b1_q, b1_d, b2_q, b2_d;
   logic [3:0]  d_q, d_d;
   logic        val_q, val_d, svc_q, svc_d, sg_q, sg_d, ab_q, ab_d;
   logic        lcv_q, lcv_d;

   // sampling, violation check, field decode
   always_comb begin
      logic       mk;
      logic       cv;
      logic       bit_v;
      logic [5:0] s;
      logic [37:0] fw;
      logic [1:0] cur;
      rx_st_d = rx_st_q; rx_ph_d = rx_ph_q; rx_idx_d = rx_idx_q;
      rx_w_d = rx_w_q; rx_h_d = rx_h_q; rx_c_d = rx_c_q;
      rx_lp_d = rx_lp_q; rx_lh_d = rx_lh_q; rx_fcv_d = rx_fcv_q;
      rx_sf_d = rx_sf_q; b1_d = b1_q; b2_d = b2_q; d_d = d_q;
      svc_d = svc_q; sg_d = sg_q; ab_d = ab_q; lcv_d = lcv_q;
      m_tick_d = 1'b0; cv_tick_d = 1'b0; val_d = 1'b0;
      mk = rx_pos_in | rx_neg_in;
      cv = mk && rx_lh_q && (rx_pos_in == rx_lp_q);
      bit_v = mk; s = 6'h00; fw = 38'h0; cur = 2'h0;
      case (rx_st_q)
         ppb_pkg::RX_HUNT: begin
            // lead bit is always a mark, so the first pulse opens the frame
            if (mk) begin
               rx_st_d  = ppb_pkg::RX_BITS;
               rx_ph_d  = 11'(BIT_CYC / 4);
               rx_idx_d = 6'h00;
            end
         end
         ppb_pkg::RX_BITS: begin
            if (rx_ph_q != 11'h000) begin
               rx_ph_d = rx_ph_q - 11'h001;
            end else begin
               rx_ph_d   = 11'(BIT_CYC - 1);
               cv_tick_d = cv;
               if (mk) begin
                  rx_lp_d = rx_pos_in;
                  rx_lh_d = 1'b1;
               end
               if (rx_idx_q == 6'h00) rx_fcv_d = cv;
               if (b_pos(rx_idx_q)) begin
                  s      = scr(mk, rx_h_q, rx_c_q);
                  bit_v  = s[5];
                  rx_c_d = s[4:0];
                  rx_h_d = {rx_h_q[6:0], mk};
               end
               rx_w_d   = {rx_w_q[36:0], bit_v};
               rx_idx_d = rx_idx_q + 6'h01;
               if (rx_idx_q == 6'(`PPB_M_IDX)) begin
                  fw       = {rx_w_q[36:0], bit_v};
                  m_tick_d = 1'b1;
                  val_d    = 1'b1;
                  lcv_d    = rx_fcv_q;
                  cur      = cv ? 2'h0 : rx_sf_q + 2'h1;
                  rx_sf_d  = cur;
                  if (cur == 2'h2) svc_d = bit_v;
                  if (cur == 2'h1 || cur == 2'h3) begin
                     ab_d = t_mapping_select_in ? bit_v : 1'b1;
                     sg_d = t_mapping_select_in ? 1'b1 : !bit_v;
                  end
                  // user data only while activated, else all ones
                  b1_d = activated_in ? {fw[36:29], fw[18:11]} : 16'hffff;
                  b2_d = activated_in ? {fw[28:21], fw[10:3]} : 16'hffff;
                  d_d  = activated_in ? {fw[20:19], fw[2:1]} : 4'hf;
                  // skip a possible balancing bit before hunting again
                  rx_st_d = ppb_pkg::RX_TAIL;
                  rx_ph_d = 11'(3 * BIT_CYC);
               end
            end
         end
         default: begin
            if (rx_ph_q != 11'h000) rx_ph_d = rx_ph_q - 11'h001;
            else rx_st_d = ppb_pkg::RX_HUNT;
         end
      endcase
   end

   // receive registers
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rx_st_q <= ppb_pkg::RX_HUNT; rx_ph_q <= 11'h000; rx_idx_q <= 6'h00;
         rx_w_q <= 38'h0; rx_h_q <= 8'h00; rx_c_q <= 5'h00;
         rx_lp_q <= 1'b0; rx_lh_q <= 1'b0; rx_fcv_q <= 1'b0; rx_sf_q <= 2'h0;
         m_tick_q <= 1'b0; cv_tick_q <= 1'b0;
         b1_q <= 16'hffff; b2_q <= 16'hffff; d_q <= 4'hf;
         val_q <= 1'b0; svc_q <= 1'b1; sg_q <= 1'b1; ab_q <= 1'b1;
         lcv_q <= 1'b0;
      end else begin
         rx_st_q <= rx_st_d; rx_ph_q <= rx_ph_d; rx_idx_q <= rx_idx_d;
         rx_w_q <= rx_w_d; rx_h_q <= rx_h_d; rx_c_q <= rx_c_d;
         rx_lp_q <= rx_lp_d; rx_lh_q <= rx_lh_d; rx_fcv_q <= rx_fcv_d;
         rx_sf_q <= rx_sf_d; m_tick_q <= m_tick_d; cv_tick_q <= cv_tick_d;
         b1_q <= b1_d; b2_q <= b2_d; d_q <= d_d;
         val_q <= val_d; svc_q <= svc_d; sg_q <= sg_d; ab_q <= ab_d;
         lcv_q <= lcv_d;
      end
   end

   // ----------------------------------------
   // transmit sequencer and line coder
   // ----------------------------------------
   ppb_pkg::tx_state_t tx_st_q, tx_st_d;
   logic [9:0]  tx_div_q, tx_div_d;   // bit divider
   logic [10:0] tx_gd_q, tx_gd_d;     // guard count
   logic [16:0] tx_wk_q, tx_wk_d;     // half burst rate timer
   logic [37:0] tx_w_q, tx_w_d;       // frame being shifted
   logic [5:0]  tx_idx_q, tx_idx_d, tx_len_q, tx_len_d;
   logic        tx_fcv_q, tx_fcv_d, tx_mcv_q, tx_mcv_d, tx_scr_q, tx_scr_d;
   logic [7:0]  tx_h_q, tx_h_d;
   logic [4:0]  tx_c_q, tx_c_d;
   logic        tx_pol_q, tx_pol_d, tx_mk_q, tx_mk_d;
   logic [1:0]  tx_sf_q, tx_sf_d;     // upstream superframe position
   logic        lp_q, lp_d, ln_q, ln_d;

   // burst start, bit shift, AMI polarity
   always_comb begin
      logic        tick;
      logic        wk;
      logic        b;
      logic        cv;
      logic        m;
      logic        pw;
      logic [5:0]  s;
      ppb_pkg::info_t inf;
      tx_st_d = tx_st_q; tx_gd_d = tx_gd_q; tx_w_d = tx_w_q;
      tx_idx_d = tx_idx_q; tx_len_d = tx_len_q; tx_fcv_d = tx_fcv_q;
      tx_mcv_d = tx_mcv_q; tx_scr_d = tx_scr_q; tx_h_d = tx_h_q;
      tx_c_d = tx_c_q; tx_pol_d = tx_pol_q; tx_mk_d = tx_mk_q;
      tx_sf_d = tx_sf_q;
      inf  = info_sel_in;
      tick = (tx_div_q == 10'h000);
      // pulse window leaves out the tick cycle, so a mark never leaks into the next bit
      pw   = !tick && (tx_div_q < 10'(BIT_CYC / 2));
      tx_div_d = (tx_div_q == 10'(BIT_CYC - 1)) ? 10'h000 : tx_div_q + 10'h001;
      // free timer for the asynchronous half-rate infos
      wk = (tx_wk_q == 17'h00000);
      tx_wk_d = wk ? 17'(WAKE_CYC - 1) : tx_wk_q - 17'h00001;
      b = 1'b0; cv = 1'b0; s = 6'h00; m = 1'b0;
      // superframe M value: violation mark, T, service, T
      case (tx_sf_q)
         2'h0:    m = 1'b1;
         2'h2:    m = tx_service_in;
         default: m = !bus_accessed_flag_in;
      endcase
      case (tx_st_q)
         ppb_pkg::TX_IDLE: begin
            tx_mk_d = 1'b0;
            // silent info starts nothing
            if ((inf == ppb_pkg::INFO_DATA || inf == ppb_pkg::INFO_SYNC) && m_tick_q) begin
               tx_st_d = ppb_pkg::TX_GUARD;
               tx_gd_d = 11'(GUARD_CYC - 1);
            end else if ((inf == ppb_pkg::INFO_WAKE || inf == ppb_pkg::SINGLE_PULSE_TEST) && wk) begin
               tx_st_d = ppb_pkg::TX_SEND;
               tx_div_d = 10'h000;
            end else if (inf == ppb_pkg::CONTINUOUS_PULSE_TEST) begin
               tx_st_d = ppb_pkg::TX_SEND;
               tx_div_d = 10'h000;
            end
            tx_idx_d = 6'h00;
            tx_scr_d = (inf == ppb_pkg::INFO_DATA);
            tx_mcv_d = (inf == ppb_pkg::INFO_DATA) && (tx_sf_q == 2'h0);
            tx_fcv_d = (inf == ppb_pkg::INFO_WAKE) || (inf == ppb_pkg::INFO_SYNC);
            // frame contents chosen per info; no balancing bit ever
            case (inf)
               ppb_pkg::INFO_DATA: begin
                  tx_w_d = {1'b1, tx_b1_in[15:8], tx_b2_in[15:8], tx_d_in[3:2],
                            tx_b1_in[7:0], tx_b2_in[7:0], tx_d_in[1:0], m};
                  tx_len_d = 6'(`PPB_FRM_BITS);
               end
               ppb_pkg::INFO_WAKE: begin
                  tx_w_d = `PPB_WAKE_PAT;
                  tx_len_d = `PPB_WAKE_LEN;
               end
               ppb_pkg::INFO_SYNC: begin
                  tx_w_d = `PPB_SYNC_PAT | 38'(m);
                  tx_len_d = `PPB_SYNC_LEN;
               end
               ppb_pkg::SINGLE_PULSE_TEST: begin
                  tx_w_d = `PPB_T1_PAT;
                  tx_len_d = `PPB_T1_LEN;
               end
               default: begin
                  tx_w_d = {38{1'b1}};
                  tx_len_d = 6'(`PPB_FRM_BITS);
               end
            endcase
         end
         ppb_pkg::TX_GUARD: begin
            // line clears before our burst goes out
            if (tx_gd_q != 11'h000) begin
               tx_gd_d = tx_gd_q - 11'h001;
            end else begin
               tx_st_d  = ppb_pkg::TX_SEND;
               tx_div_d = 10'h000;
            end
         end
         default: begin
            if (tick) begin
               if (tx_idx_q < tx_len_q) begin
                  b = tx_w_q[37];
                  if (tx_scr_q && b_pos(tx_idx_q)) begin
                     s      = scr(b, tx_h_q, tx_c_q);
                     b      = s[5];
                     tx_c_d = s[4:0];
                     tx_h_d = {tx_h_q[6:0], s[5]};
                  end
                  cv = (tx_idx_q == 6'h00 && tx_fcv_q)
                     || (tx_idx_q == 6'(`PPB_M_IDX) && tx_mcv_q);
                  // violation repeats the last polarity
                  if (b && !cv) tx_pol_d = !tx_pol_q;
                  tx_mk_d  = b;
                  tx_w_d   = {tx_w_q[36:0], 1'b0};
                  tx_idx_d = tx_idx_q + 6'h01;
               end else if (info_sel_in == ppb_pkg::CONTINUOUS_PULSE_TEST) begin
                  // continuous pulses: refill and keep going
                  tx_w_d   = {{37{1'b1}}, 1'b0};
                  tx_idx_d = 6'h01;
                  tx_mk_d  = 1'b1;
                  tx_pol_d = !tx_pol_q;
               end else begin
                  tx_st_d = ppb_pkg::TX_IDLE;
                  tx_mk_d = 1'b0;
                  if (tx_scr_q) tx_sf_d = tx_sf_q + 2'h1;
               end
            end
         end
      endcase
      // half-width pulse in the first half of the bit
      lp_d = tx_mk_q && tx_pol_q && pw;
      ln_d = tx_mk_q && !tx_pol_q && pw;
   end

   // transmit registers
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         tx_st_q <= ppb_pkg::TX_IDLE; tx_div_q <= 10'h000; tx_gd_q <= 11'h000;
         tx_wk_q <= 17'h00000; tx_w_q <= 38'h0; tx_idx_q <= 6'h00;
         tx_len_q <= 6'h00; tx_fcv_q <= 1'b0; tx_mcv_q <= 1'b0;
         tx_scr_q <= 1'b0; tx_h_q <= 8'h00; tx_c_q <= 5'h00;
         tx_pol_q <= 1'b0; tx_mk_q <= 1'b0; tx_sf_q <= 2'h0;
         lp_q <= 1'b0; ln_q <= 1'b0;
      end else begin
         tx_st_q <= tx_st_d; tx_div_q <= tx_div_d; tx_gd_q <= tx_gd_d;
         tx_wk_q <= tx_wk_d; tx_w_q <= tx_w_d; tx_idx_q <= tx_idx_d;
         tx_len_q <= tx_len_d; tx_fcv_q <= tx_fcv_d; tx_mcv_q <= tx_mcv_d;
         tx_scr_q <= tx_scr_d; tx_h_q <= tx_h_d; tx_c_q <= tx_c_d;
         tx_pol_q <= tx_pol_d; tx_mk_q <= tx_mk_d; tx_sf_q <= tx_sf_d;
         lp_q <= lp_d; ln_q <= ln_d;
      end
   end

   // ----------------------------------------
   // highway clocks
   // ----------------------------------------
   logic [6:0] hc_q, hc_d;      // half period of double-bit clock
   logic       dcl_q, dcl_d, bc_q, bc_d, fs_q, fs_d;
   logic [7:0] slot_q, slot_d;  // double-bit clock periods in frame
   logic       sp_q, sp_d;      // short sync pending
   logic       sn_q, sn_d;      // this frame uses short sync

   // divider, frame counter, phase snap on M-bit
   always_comb begin
      hc_d = hc_q; dcl_d = dcl_q; bc_d = bc_q; slot_d = slot_q;
      sn_d = sn_q;
      sp_d = sp_q;
      if (hc_q == 7'(DCL_HALF - 1)) begin
         hc_d  = 7'h00;
         dcl_d = !dcl_q;
         if (!dcl_q) begin
            bc_d   = !bc_q;
            slot_d = (slot_q == 8'(`PPB_FRM_SLOTS - 1)) ? 8'h00 : slot_q + 8'h01;
            if (slot_d == 8'h00) begin
               // only frames that open during a line frame carry the mark
               sn_d = sp_q && (rx_st_q == ppb_pkg::RX_BITS);
               if (sn_d) sp_d = 1'b0;
            end
         end
      end else begin
         hc_d = hc_q + 7'h01;
      end
      // crude lock: snapping the phase may cut one clock short
      if (m_tick_q) begin
         hc_d = 7'h00; dcl_d = 1'b0; bc_d = 1'b0;
         slot_d = 8'(LOCK_SLOT);
      end
      if (cv_tick_q) sp_d = 1'b1;
      fs_d = (slot_d == 8'h00) || (slot_d == 8'h01 && !sn_d);
   end

   // highway registers
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         hc_q <= 7'h00; dcl_q <= 1'b0; bc_q <= 1'b0; fs_q <= 1'b0;
         slot_q <= 8'h00; sp_q <= 1'b0; sn_q <= 1'b0;
      end else begin
         hc_q <= hc_d; dcl_q <= dcl_d; bc_q <= bc_d; fs_q <= fs_d;
         slot_q <= slot_d; sp_q <= sp_d; sn_q <= sn_d;
      end
   end

   // ----------------------------------------
   // outputs, all from flip-flops
   // ----------------------------------------
   assign line_pos_out      = lp_q;
   assign line_neg_out      = ln_q;
   assign rx_b1_out         = b1_q;
   assign rx_b2_out         = b2_q;
   assign rx_d_out          = d_q;
   assign rx_valid_out      = val_q;
   assign rx_service_out    = svc_q;
   assign rx_stop_go_out    = sg_q;
   assign rx_avail_busy_out = ab_q;
   assign rx_lead_cv_out    = lcv_q;
   assign frame_sync_out    = fs_q;
   assign dcl_out           = dcl_q;
   assign bit_clk_out       = bc_q;
endmodule : ping_pong_burst_transceiver

// File: ping_pong_burst_transceiver_properties.sv
// port-level checks of the burst transceiver
`timescale 1ns/10ps
module ppb_props (
   // clock, reset and controls
   input wire logic           clk_in,
   input wire logic           rst_n_in,
   input wire ppb_pkg::info_t info_sel_in,
   input wire logic           activated_in,
   input wire logic           t_mapping_select_in,
   // observed outputs
   input wire logic           line_pos_out,
   input wire logic           line_neg_out,
   input wire logic [15:0]    rx_b1_out,
   input wire logic [15:0]    rx_b2_out,
   input wire logic [3:0]     rx_d_out,
   input wire logic           rx_valid_out,
   input wire logic           rx_stop_go_out,
   input wire logic           rx_avail_busy_out,
   input wire logic           frame_sync_out,
   input wire logic           dcl_out,
   input wire logic           bit_clk_out
);
   // ----------------------------------------
   // helper counters
   // ----------------------------------------
   int   gcnt;  // cycles since a frame was taken, zero outside the guard
   int   scnt;  // cycles with silence selected, saturates past any burst
   logic pulse; // any mark on the line
   assign pulse = line_pos_out | line_neg_out;
   // count the guard and the silent span
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gcnt <= 0;
         scnt <= 0;
      end else begin
         gcnt <= rx_valid_out ? 1 : ((gcnt != 0 && gcnt < 1040) ? gcnt + 1 : 0);
         scnt <= (info_sel_in != ppb_pkg::INFO_SILENT) ? 0 : ((scnt < 21000) ? scnt + 1 : scnt);
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // pulse tail and highway sync tail
   sequence s_pos_end;
      ##250 line_pos_out ##[1:12] !line_pos_out;
   endsequence
   sequence s_sync_end;
      ##120 frame_sync_out ##[1:150] !frame_sync_out;
   endsequence
   a_guard_quiet: assert property (
      gcnt != 0 && info_sel_in == ppb_pkg::INFO_DATA |-> !pulse)
      else $error("mark sent inside guard time");
   a_line_silent: assert property (scnt == 21000 |-> !pulse)
      else $error("mark sent while silent");
   a_one_polarity: assert property (!(line_pos_out && line_neg_out))
      else $error("both polarities driven");
   a_pulse_half: assert property ($rose(line_pos_out) |-> s_pos_end)
      else $error("mark width not half a bit");
   a_valid_single: assert property (rx_valid_out |=> !rx_valid_out)
      else $error("frame valid longer than one cycle");
   a_ones_idle: assert property (
      rx_valid_out && !activated_in |-> rx_b1_out == 16'hffff
      && rx_b2_out == 16'hffff && rx_d_out == 4'hf)
      else $error("data passed while not activated");
   a_tmap_set: assert property (rx_valid_out && t_mapping_select_in |-> rx_stop_go_out)
      else $error("stop go not held with select set");
   a_tmap_clear: assert property (rx_valid_out && !t_mapping_select_in |-> rx_avail_busy_out)
      else $error("busy not held with select clear");
   a_sync_len: assert property ($rose(frame_sync_out) |-> s_sync_end)
      else $error("frame sync length wrong");
   a_dcl_half: assert property ($rose(dcl_out) |-> ##64 dcl_out ##1 !dcl_out)
      else $error("double bit clock half period wrong");
   a_bit_clk_step: assert property ($rose(dcl_out) |-> bit_clk_out != $past(bit_clk_out))
      else $error("bit clock not stepped by double bit clock");
endmodule : ppb_props
bind ping_pong_burst_transceiver ppb_props ppb_props_inst (.clk_in, .rst_n_in, .info_sel_in,
   .activated_in, .t_mapping_select_in, .line_pos_out, .line_neg_out, .rx_b1_out, .rx_b2_out,
   .rx_d_out, .rx_valid_out, .rx_stop_go_out, .rx_avail_busy_out, .frame_sync_out, .dcl_out,
   .bit_clk_out);

// File: line_card_model.sv
// exchange line end model driving the receive comparators
`timescale 1ns/10ps
module line_card_model (
   input  wire logic clk_in,
   output logic      rx_pos_out,
   output logic      rx_neg_out
);
   logic last_neg = 1'b1; // polarity of the last mark, kept across bursts
   initial begin
      rx_pos_out = 1'b0;
      rx_neg_out = 1'b0;
   end
   // callers leave a wide gap after any upstream burst
   // one burst msb first at 520 cycles a bit, half-width marks
   task automatic send_frame(input logic [37:0] bits, input logic m_cv);
      logic neg;
      for (int i = 37; i >= 0; i--) begin
         neg = (i == 0 && m_cv) ? last_neg : !last_neg; // m mark repeats polarity
         if (bits[i]) last_neg = neg;
         @(posedge clk_in);
         rx_pos_out <= bits[i] && !neg;
         rx_neg_out <= bits[i] && neg;
         repeat (260) @(posedge clk_in);
         rx_pos_out <= 1'b0;
         rx_neg_out <= 1'b0;
         repeat (259) @(posedge clk_in);
      end
   endtask : send_frame
endmodule : line_card_model

// File: test_ping_pong_burst_transceiver.sv
// self-checking bench of the burst transceiver
`timescale 1ns/10ps
module test_ping_pong_burst_transceiver;
   logic clk_in = 1'b0, rst_n_in = 1'b0, activated_in = 1'b0, t_mapping_select_in = 1'b1;
   logic terminal_repeater_mode_in = 1'b1, bus_accessed_flag_in = 1'b0, tx_service_in = 1'b1;
   logic [15:0] tx_b1_in = 16'h1234, tx_b2_in = 16'h5678;
   logic [3:0]  tx_d_in = 4'ha;
   ppb_pkg::info_t info_sel_in = ppb_pkg::INFO_SILENT;
   wire logic rx_pos_in, rx_neg_in, line_pos_out, line_neg_out, rx_valid_out, rx_service_out;
   wire logic rx_stop_go_out, rx_avail_busy_out, rx_lead_cv_out, frame_sync_out, dcl_out;
   wire logic bit_clk_out;
   wire logic [15:0] rx_b1_out, rx_b2_out;
   wire logic [3:0]  rx_d_out;
   int mismatches = 0, check_count = 0;
   ping_pong_burst_transceiver ping_pong_burst_transceiver_inst (.clk_in, .rst_n_in,
      .info_sel_in, .activated_in, .terminal_repeater_mode_in, .t_mapping_select_in,
      .bus_accessed_flag_in, .tx_b1_in, .tx_b2_in, .tx_d_in, .tx_service_in, .rx_pos_in,
      .rx_neg_in, .line_pos_out, .line_neg_out, .rx_b1_out, .rx_b2_out, .rx_d_out,
      .rx_valid_out, .rx_service_out, .rx_stop_go_out, .rx_avail_busy_out, .rx_lead_cv_out,
      .frame_sync_out, .dcl_out, .bit_clk_out);
   line_card_model line_card_model_inst (.clk_in, .rx_pos_out(rx_pos_in), .rx_neg_out(rx_neg_in));
   always #2.5 clk_in = ~clk_in; // 200 MHz
   // compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim();
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   // bounded wait for a received frame
   task automatic wait_valid();
      int n;
      n = 0;
      while (rx_valid_out !== 1'b1 && n < 25000) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      check(16'(n < 25000), 16'h0001);
   endtask : wait_valid
   // reset values before any frame
   task automatic t_reset_vals();
      check({rx_b1_out}, 16'hffff);
      check({12'h000, rx_d_out}, 16'h000f);
      check({14'h0, rx_stop_go_out, rx_avail_busy_out}, 16'h0003);
      check({15'h0, rx_service_out}, 16'h0001);
   endtask : t_reset_vals
   // not activated: data stays ones, m violation opens superframe
   task automatic t_frame_idle();
      fork
         line_card_model_inst.send_frame({1'b1, 16'h0000, 2'h2, 16'h0000, 2'h1, 1'b1}, 1'b1);
         wait_valid();
      join_any
      check(rx_b2_out, 16'hffff);
      check({12'h000, rx_d_out}, 16'h000f);
      check({15'h0, rx_lead_cv_out}, 16'h0000);
   endtask : t_frame_idle
   // activated: d bits pass, t bit after the violation maps to stop/go
   task automatic t_frame_live();
      repeat (3000) @(posedge clk_in);
      activated_in <= 1'b1;
      t_mapping_select_in <= 1'b0;
      info_sel_in <= ppb_pkg::INFO_DATA;
      fork
         line_card_model_inst.send_frame({1'b1, 16'h0000, 2'h3, 16'h0000, 2'h0, 1'b1}, 1'b0);
         wait_valid();
      join_any
      check({12'h000, rx_d_out}, 16'h000c);
      check(rx_b1_out, 16'h0000);
      check(rx_b2_out, 16'h0001);
      check({14'h0, rx_stop_go_out, rx_avail_busy_out}, 16'h0001);
   endtask : t_frame_live
   // upstream burst starts with the lead mark just after the guard
   task automatic t_guard();
      int n;
      n = 0;
      while (line_pos_out !== 1'b1 && line_neg_out !== 1'b1 && n < 1500) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      check(16'(n >= 1040), 16'h0001);
      check(16'(n < 1100), 16'h0001);
      repeat (20000) @(posedge clk_in);
   endtask : t_guard
   // continuous test pulses swap polarity every bit
   task automatic t_cont_pulse();
      int   n;
      logic first_pos;
      n = 0;
      info_sel_in <= ppb_pkg::CONTINUOUS_PULSE_TEST;
      while (line_pos_out !== 1'b1 && line_neg_out !== 1'b1 && n < 1200) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      first_pos = line_pos_out;
      n = 0;
      while ((first_pos ? line_neg_out : line_pos_out) !== 1'b1 && n < 1200) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      check(16'(n), 16'h0208);
   endtask : t_cont_pulse
   initial begin
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      t_reset_vals();
      t_frame_idle();
      t_frame_live();
      t_guard();
      t_cont_pulse();
      end_sim();
   end
   // watchdog against a hang
   initial begin
      repeat (90000) @(posedge clk_in);
      mismatches++;
      end_sim();
   end
endmodule : test_ping_pong_burst_transceiver
